// ### core/poecfg_pkg.sv
// constants, state layout and timing tables of the port config block
// assumes a serial bus engine outside drives the byte-wide register port
package poecfg_pkg;
   localparam logic [7:0] ADDR_OPMODE  = 8'h12;
   localparam logic [7:0] ADDR_DISC    = 8'h13;
   localparam logic [7:0] ADDR_DETCLS  = 8'h14;
   localparam logic [7:0] ADDR_TIMING  = 8'h16;
   localparam logic [7:0] ADDR_MISC    = 8'h17;
   localparam logic [7:0] ADDR_RESTART = 8'h18;
   localparam logic [7:0] ADDR_POWER   = 8'h19;
   localparam logic [7:0] ADDR_RESET   = 8'h1A;

   localparam logic [1:0] MODE_SHUTDOWN = 2'h0;
   localparam logic [1:0] MODE_MANUAL   = 2'h1;
   localparam logic [1:0] MODE_SEMIAUTO = 2'h2;
   localparam logic [1:0] MODE_AUTO     = 2'h3;

   localparam int TIM_DISC_LSB  = 0;
   localparam int TIM_OVC_LSB   = 2;
   localparam int TIM_START_LSB = 4;
   localparam int MISC_OSC_MASK = 5;
   localparam int MISC_INT_EN   = 7;
   localparam int RST_ALL       = 4;
   localparam int RST_INT_REL   = 6;
   localparam int RST_CLR_ALL   = 7;

   localparam int SYN_AUTO = 0;
   localparam int SYN_OSC  = 1;
   localparam int SYN_HOLD = 2;
   localparam int SYN_AC   = 6;
   localparam int SYN_OVC  = 10;
   localparam int SYN_W    = 14;

   localparam logic [2:0] LOAD_SETTLE = 3'h4;

   localparam int CLK_PERIOD_NS  = 100;
   localparam int TICK_PERIOD_US = 1000;
   localparam int TICK_CYCLES    = TICK_PERIOD_US * 1000 / CLK_PERIOD_NS;

   // delays in milliseconds, indexed by the 2-bit timing code
   localparam int TIMER_W = 10;
   localparam logic [3:0][9:0] DISC_DELAY_MS  =
      {10'h320, 10'h190, 10'h0C8, 10'h064};
   localparam logic [3:0][9:0] OVC_DELAY_MS   =
      {10'h0C8, 10'h064, 10'h019, 10'h032};
   localparam logic [3:0][9:0] START_DELAY_MS =
      {10'h0C8, 10'h064, 10'h019, 10'h032};

   typedef struct packed {
      logic [SYN_W-1:0]        sync1;
      logic [SYN_W-1:0]        sync2;
      logic [SYN_W-1:0]        sync3;
      logic [SYN_W-1:0]        filt;
      logic                    loading;
      logic [2:0]              settle;
      logic [13:0]             tick_cnt;
      logic                    tick;
      logic [7:0]              mode;
      logic [7:0]              disc_en;
      logic [7:0]              detcls_en;
      logic [5:0]              timing;
      logic                    osc_mask;
      logic                    int_en;
      logic [3:0]              pwr;
      logic [3:0]              starting;
      logic [3:0]              fault_off;
      logic [3:0][TIMER_W-1:0] st_cnt;
      logic [3:0][TIMER_W-1:0] ovc_cnt;
      logic [3:0][TIMER_W-1:0] dis_cnt;
      logic [3:0]              det_run;
      logic [3:0]              cls_run;
      logic [3:0]              det_once;
      logic [3:0]              cls_once;
      logic [3:0]              port_clear;
      logic [3:0]              ovc_fault;
      logic [3:0]              start_fault;
      logic [3:0]              disc_evt;
      logic                    dev_reset;
      logic                    clear_all;
      logic                    osc_flag_set;
      logic                    int_released;
      logic                    int_oe_n;
      logic                    int_out;
      logic [7:0]              rdata;
   } poecfg_state_t;
endpackage : poecfg_pkg

// ### core/poecfg_top.sv
// port configuration and one-shot register logic of a four-port source
// assumes a bus engine on core_clk gives one-cycle reg_write/reg_read
`timescale 1ns/1ps
module poecfg_top #(
   parameter int TICK_CYCLES = poecfg_pkg::TICK_CYCLES
) (
   input  wire logic       core_clk,
   input  wire logic       reset,
   input  wire logic       ce,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_write,
   input  wire logic       reg_read,
   input  wire logic       auto_start_pin,
   input  wire logic       ac_sense_oscillator_input_fail,
   input  wire logic [3:0] below_minimum_hold_current,
   input  wire logic [3:0] below_minimum_ac_sense_current,
   input  wire logic [3:0] above_overcurrent_threshold,
   input  wire logic [3:0] detect_good,
   input  wire logic       int_request,
   output logic      [7:0] reg_rdata,
   output logic      [3:0] port_power_on,
   output logic      [3:0] detect_enable,
   output logic      [3:0] classify_enable,
   output logic      [3:0] detect_single,
   output logic      [3:0] classify_single,
   output logic      [3:0] port_clear,
   output logic      [3:0] overcurrent_fault,
   output logic      [3:0] startup_fault,
   output logic      [3:0] disconnect_event,
   output logic            device_reset_pulse,
   output logic            event_clear_all,
   output logic            osc_fail_flag_set,
   output logic            alert_response_enable,
   output logic            int_out,
   output logic            int_oe_n
);
   localparam logic [13:0] TICK_LAST = 14'(TICK_CYCLES - 1);

   poecfg_pkg::poecfg_state_t st;
   poecfg_pkg::poecfg_state_t nx;

   function automatic poecfg_pkg::poecfg_state_t reset_state();
      poecfg_pkg::poecfg_state_t r;
      r = '0;
      r.loading  = 1'b1;
      r.osc_mask = 1'b1;
      r.int_en   = 1'b1;
      r.int_oe_n = 1'b1;
      return r;
   endfunction : reset_state

   localparam int SYN_W_L = poecfg_pkg::SYN_W;
   logic [SYN_W_L-1:0] agree;
   logic [7:0]         once_req;
   logic [7:0]         restart_set;
   logic [3:0]         pwr_set;
   logic [3:0]         pwr_clr;
   logic [3:0]         port_rst;
   logic               soft_rst;
   logic               int_rel;
   logic               clr_all;
   logic               auto_lvl;
   logic [3:0]         hold_low;
   logic [3:0]         ac_low;
   logic [3:0]         ovc_hi;
   logic [1:0]         m;
   logic [1:0]         nm;
   logic               refuse;
   logic               kill;
   logic               sense_en;
   logic               present;
   logic [9:0]         dis_lim;
   logic [9:0]         ovc_lim;
   logic [9:0]         start_lim;

   always_comb begin
      nx = st;
      once_req = 8'h00;
      restart_set = 8'h00;
      pwr_set = 4'h0;
      pwr_clr = 4'h0;
      port_rst = 4'h0;
      soft_rst = 1'b0;
      int_rel = 1'b0;
      clr_all = 1'b0;
      m = 2'h0;
      nm = 2'h0;
      refuse = 1'b0;
      kill = 1'b0;
      sense_en = 1'b0;
      present = 1'b0;
      nx.det_once = 4'h0;
      nx.cls_once = 4'h0;
      nx.port_clear = 4'h0;
      nx.ovc_fault = 4'h0;
      nx.start_fault = 4'h0;
      nx.disc_evt = 4'h0;
      nx.dev_reset = 1'b0;
      nx.clear_all = 1'b0;
      nx.tick = 1'b0;
      // three-stage capture; value changes once stages two and three agree
      nx.sync1 = {above_overcurrent_threshold, below_minimum_ac_sense_current,
                  below_minimum_hold_current, ac_sense_oscillator_input_fail,
                  auto_start_pin};
      nx.sync2 = st.sync1;
      nx.sync3 = st.sync2;
      agree = ~(st.sync2 ^ st.sync3);
      nx.filt = (st.filt & ~agree) | (st.sync2 & agree);
      auto_lvl = st.filt[poecfg_pkg::SYN_AUTO];
      hold_low = st.filt[poecfg_pkg::SYN_HOLD +: 4];
      ac_low = st.filt[poecfg_pkg::SYN_AC +: 4];
      ovc_hi = st.filt[poecfg_pkg::SYN_OVC +: 4];
      dis_lim = poecfg_pkg::DISC_DELAY_MS[st.timing[1:0]];
      ovc_lim = poecfg_pkg::OVC_DELAY_MS[st.timing[3:2]];
      start_lim = poecfg_pkg::START_DELAY_MS[st.timing[5:4]];

      if (st.tick_cnt == TICK_LAST) begin
         nx.tick_cnt = 14'h0000;
         nx.tick = 1'b1;
      end else begin
         nx.tick_cnt = st.tick_cnt + 14'h0001;
      end

      // strap load once the capture stages hold the pin level
      if (st.loading) begin
         if (st.settle == poecfg_pkg::LOAD_SETTLE) begin
            nx.loading = 1'b0;
            nx.mode = {8{auto_lvl}};
            nx.detcls_en = {8{auto_lvl}};
            nx.disc_en = {4'h0, {4{auto_lvl}}};
         end else begin
            nx.settle = st.settle + 3'h1;
         end
      end

      if (reg_write) begin
         case (reg_addr)
            poecfg_pkg::ADDR_OPMODE: nx.mode = reg_wdata;
            poecfg_pkg::ADDR_DISC: nx.disc_en = reg_wdata;
            poecfg_pkg::ADDR_DETCLS: begin
               nx.detcls_en = reg_wdata;
               once_req = reg_wdata;
            end
            poecfg_pkg::ADDR_TIMING: nx.timing = reg_wdata[5:0];
            poecfg_pkg::ADDR_MISC: begin
               nx.osc_mask = reg_wdata[poecfg_pkg::MISC_OSC_MASK];
               nx.int_en = reg_wdata[poecfg_pkg::MISC_INT_EN];
            end
            poecfg_pkg::ADDR_RESTART: begin
               once_req = reg_wdata;
               restart_set = reg_wdata;
            end
            poecfg_pkg::ADDR_POWER: begin
               pwr_set = reg_wdata[3:0];
               pwr_clr = reg_wdata[7:4];
            end
            poecfg_pkg::ADDR_RESET: begin
               port_rst = reg_wdata[3:0];
               soft_rst = reg_wdata[poecfg_pkg::RST_ALL];
               int_rel = reg_wdata[poecfg_pkg::RST_INT_REL];
               clr_all = reg_wdata[poecfg_pkg::RST_CLR_ALL];
            end
            default: ;
         endcase
      end

      if (reg_read) begin
         case (reg_addr)
            poecfg_pkg::ADDR_OPMODE: nx.rdata = st.mode;
            poecfg_pkg::ADDR_DISC: nx.rdata = st.disc_en;
            poecfg_pkg::ADDR_DETCLS: nx.rdata = st.detcls_en;
            poecfg_pkg::ADDR_TIMING: nx.rdata = {2'h0, st.timing};
            poecfg_pkg::ADDR_MISC:
               nx.rdata = {st.int_en, 1'b0, st.osc_mask, 5'h00};
            default: nx.rdata = 8'h00;
         endcase
      end

      for (int i = 0; i < 4; i++) begin
         m = st.mode[2*i +: 2];
         nm = nx.mode[2*i +: 2];
         kill = 1'b0;
         // one shot cycles for manual ports only
         if (m == poecfg_pkg::MODE_MANUAL) begin
            nx.det_once[i] = once_req[i];
            nx.cls_once[i] = once_req[i+4];
         end
         if (m == poecfg_pkg::MODE_AUTO || m == poecfg_pkg::MODE_SEMIAUTO) begin
            if (restart_set[i]) begin
               nx.detcls_en[i] = 1'b1;
            end
            if (restart_set[i+4]) begin
               nx.detcls_en[i+4] = 1'b1;
            end
         end

         refuse = st.fault_off[i] && (st.ovc_cnt[i] != '0);
         if (st.fault_off[i] && st.ovc_cnt[i] == '0) begin
            nx.fault_off[i] = 1'b0;
         end
         if (nm != poecfg_pkg::MODE_SHUTDOWN && !refuse && !st.pwr[i] &&
             (pwr_set[i] || (m == poecfg_pkg::MODE_AUTO &&
                             detect_good[i]))) begin
            nx.pwr[i] = 1'b1;
            nx.starting[i] = 1'b1;
            nx.st_cnt[i] = '0;
            nx.dis_cnt[i] = '0;
         end

         // overcurrent timer also counts back down while the port is off
         if (st.tick && st.pwr[i]) begin
            if (st.starting[i]) begin
               if (!ovc_hi[i]) begin
                  nx.starting[i] = 1'b0;
               end else if (st.st_cnt[i] == start_lim - 10'h001) begin
                  kill = 1'b1;
                  nx.start_fault[i] = 1'b1;
                  nx.fault_off[i] = 1'b1;
                  nx.ovc_cnt[i] = ovc_lim;
               end else begin
                  nx.st_cnt[i] = st.st_cnt[i] + 10'h001;
               end
            end else if (ovc_hi[i]) begin
               if (st.ovc_cnt[i] >= ovc_lim - 10'h001) begin
                  kill = 1'b1;
                  nx.ovc_fault[i] = 1'b1;
                  nx.fault_off[i] = 1'b1;
                  nx.ovc_cnt[i] = ovc_lim;
               end else begin
                  nx.ovc_cnt[i] = st.ovc_cnt[i] + 10'h001;
               end
            end else if (st.ovc_cnt[i] != '0) begin
               nx.ovc_cnt[i] = st.ovc_cnt[i] - 10'h001;
            end
         end else if (st.tick && st.ovc_cnt[i] != '0) begin
            nx.ovc_cnt[i] = st.ovc_cnt[i] - 10'h001;
         end

         sense_en = st.disc_en[i] || st.disc_en[i+4];
         present = (st.disc_en[i] && !hold_low[i]) ||
                   (st.disc_en[i+4] && !ac_low[i]);
         if (!sense_en || present) begin
            nx.dis_cnt[i] = '0;
         end else if (st.tick && st.pwr[i]) begin
            if (st.dis_cnt[i] == dis_lim - 10'h001) begin
               kill = 1'b1;
               nx.disc_evt[i] = 1'b1;
            end else begin
               nx.dis_cnt[i] = st.dis_cnt[i] + 10'h001;
            end
         end

         if (kill || pwr_clr[i] || port_rst[i] ||
             nm == poecfg_pkg::MODE_SHUTDOWN) begin
            nx.pwr[i] = 1'b0;
            nx.starting[i] = 1'b0;
            nx.dis_cnt[i] = '0;
         end
         if (pwr_clr[i] || port_rst[i] || nm == poecfg_pkg::MODE_SHUTDOWN) begin
            nx.detcls_en[i] = 1'b0;
            nx.detcls_en[i+4] = 1'b0;
            nx.det_once[i] = 1'b0;
            nx.cls_once[i] = 1'b0;
            nx.port_clear[i] = 1'b1;
         end
         nx.det_run[i] = nx.detcls_en[i] && nm[1];
         nx.cls_run[i] = nx.detcls_en[i+4] && nm[1];
      end

      nx.osc_flag_set = st.filt[poecfg_pkg::SYN_OSC] && st.osc_mask;
      nx.clear_all = clr_all;
      if (int_rel || clr_all) begin
         nx.int_released = 1'b1;
      end else if (!int_request) begin
         nx.int_released = 1'b0;
      end
      nx.int_oe_n = !(nx.int_en && int_request && !nx.int_released);
      nx.int_out = 1'b0;

      if (soft_rst) begin
         nx = reset_state();
         nx.sync1 = st.sync1;
         nx.sync2 = st.sync2;
         nx.sync3 = st.sync3;
         nx.filt = st.filt;
         nx.dev_reset = 1'b1;
         nx.clear_all = clr_all;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         st <= reset_state();
      end else if (ce) begin
         st <= nx;
      end
   end

   assign reg_rdata = st.rdata;
   assign port_power_on = st.pwr;
   assign detect_enable = st.det_run;
   assign classify_enable = st.cls_run;
   assign detect_single = st.det_once;
   assign classify_single = st.cls_once;
   assign port_clear = st.port_clear;
   assign overcurrent_fault = st.ovc_fault;
   assign startup_fault = st.start_fault;
   assign disconnect_event = st.disc_evt;
   assign device_reset_pulse = st.dev_reset;
   assign event_clear_all = st.clear_all;
   assign osc_fail_flag_set = st.osc_flag_set;
   assign alert_response_enable = st.int_en;
   assign int_out = st.int_out;
   assign int_oe_n = st.int_oe_n;

   logic wr_restart;
   logic wr_power;
   logic wr_reset;
   logic refuse0;
   assign wr_restart = reg_write && reg_addr == poecfg_pkg::ADDR_RESTART;
   assign wr_power = reg_write && reg_addr == poecfg_pkg::ADDR_POWER;
   assign wr_reset = reg_write && reg_addr == poecfg_pkg::ADDR_RESET;
   assign refuse0 = st.fault_off[0] && st.ovc_cnt[0] != '0;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset || !ce);

   property p_pb_read_zero;
      reg_read && (reg_addr == poecfg_pkg::ADDR_RESTART ||
         reg_addr == poecfg_pkg::ADDR_POWER ||
         reg_addr == poecfg_pkg::ADDR_RESET) |=> reg_rdata == 8'h00;
   endproperty
   a_pb_read_zero: assert property (p_pb_read_zero)
      else $error("one-shot register read not zero");

   property p_timing_reserved;
      reg_read && reg_addr == poecfg_pkg::ADDR_TIMING |=> reg_rdata[7:6] == 2'h0;
   endproperty
   a_timing_reserved: assert property (p_timing_reserved)
      else $error("timing reserved bits not zero");

   property p_shutdown_off;
      st.mode[1:0] == poecfg_pkg::MODE_SHUTDOWN |=> !port_power_on[0];
   endproperty
   a_shutdown_off: assert property (p_shutdown_off)
      else $error("shutdown port powered");

   property p_int_disabled;
      !alert_response_enable |-> int_oe_n;
   endproperty
   a_int_disabled: assert property (p_int_disabled)
      else $error("interrupt driven while disabled");

   property p_clear_all;
      wr_reset && reg_wdata[7] |=> event_clear_all && int_oe_n ##1 !event_clear_all;
   endproperty
   a_clear_all: assert property (p_clear_all)
      else $error("clear-all did not pulse or release");

   property p_int_release;
      wr_reset && reg_wdata[6] && !reg_wdata[4] |=>
         int_oe_n && event_clear_all == $past(reg_wdata[7]);
   endproperty
   a_int_release: assert property (p_int_release)
      else $error("interrupt not released");

   property p_power_clear;
      wr_power && reg_wdata[4] |=> !port_power_on[0] && port_clear[0];
   endproperty
   a_power_clear: assert property (p_power_clear)
      else $error("power clear failed");

   property p_refuse;
      wr_power && reg_wdata[0] && refuse0 && !port_power_on[0] |=> !port_power_on[0];
   endproperty
   a_refuse: assert property (p_refuse)
      else $error("power set accepted during fault cooldown");

   property p_port_reset;
      wr_reset && reg_wdata[0] |=> !port_power_on[0] && !detect_enable[0];
   endproperty
   a_port_reset: assert property (p_port_reset)
      else $error("port reset incomplete");

   property p_global_reset;
      wr_reset && reg_wdata[4] |=> device_reset_pulse && port_power_on == 4'h0;
   endproperty
   a_global_reset: assert property (p_global_reset)
      else $error("global reset incomplete");

   property p_osc_mask;
      !st.osc_mask |=> !osc_fail_flag_set;
   endproperty
   a_osc_mask: assert property (p_osc_mask)
      else $error("oscillator flag set while masked");

   property p_manual_once;
      wr_restart && reg_wdata[0] && st.mode[1:0] == poecfg_pkg::MODE_MANUAL
         |=> detect_single[0];
   endproperty
   a_manual_once: assert property (p_manual_once)
      else $error("manual restart did not start a cycle");

   property p_auto_restart;
      wr_restart && reg_wdata[4] && st.mode[1:0] == poecfg_pkg::MODE_AUTO
         |=> st.detcls_en[4];
   endproperty
   a_auto_restart: assert property (p_auto_restart)
      else $error("restart did not set classify enable");

   c_auto_power: cover property (detect_good[0] ##1 port_power_on[0]);
   c_ovc_fault: cover property (overcurrent_fault[0]);
   c_disconnect: cover property (disconnect_event[1]);
   c_int_release: cover property (!int_oe_n ##1 wr_reset ##1 int_oe_n);
endmodule : poecfg_top

// ### sim/poecfg_host_model.sv
// host side model: one-cycle register strobes on core_clk
// assumes the bench calls wr and rd one at a time
`timescale 1ns/1ps
module poecfg_host_model (
   input  wire logic       core_clk,
   output logic      [7:0] reg_addr,
   output logic      [7:0] reg_wdata,
   output logic            reg_write,
   output logic            reg_read
);
   initial begin
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_write = 1'b0;
      reg_read = 1'b0;
   end
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= (a == poecfg_pkg::ADDR_TIMING) ? (d & 8'h3F) : d;
      reg_write <= 1'b1;
      @(posedge core_clk);
      reg_write <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~d;
      #1;
   endtask : wr
   task rd(input logic [7:0] a);
      @(posedge core_clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge core_clk);
      reg_read <= 1'b0;
      reg_addr <= ~a;
      #1;
   endtask : rd
endmodule : poecfg_host_model

// ### sim/poecfg_top_tb_top.sv
// bench for the port config block: host model plus read queue checker
// assumes strap high at reset, so every port starts in auto mode
`timescale 1ns/1ps
module poecfg_top_tb_top;
   logic       core_clk = 1'b0;
   logic       reset = 1'b1;
   logic       osc_fail = 1'b0;
   logic [3:0] low_dc = 4'h0;
   logic       int_req = 1'b0;
   logic       ce = 1'b1;
   logic [3:0] ovc = 4'h0;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   logic       reg_write, reg_read, rd_pend = 1'b0;
   logic [3:0] pwr, d_single, unused_a, unused_b, unused_c, unused_d;
   logic       dev_rst, clr_all, osc_set, alert_en, int_oe_n;
   logic [7:0] q[$];
   logic [31:0] lfsr = 32'h5580;
   int n_mismatch = 0;
   int checks = 0;
   int i;
   always #50 core_clk = ~core_clk;
   poecfg_host_model i_poecfg_host_model (.core_clk(core_clk),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
      .reg_read(reg_read));
   poecfg_top #(.TICK_CYCLES(10)) i_poecfg_top (.core_clk(core_clk),
      .reset(reset), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .auto_start_pin(1'b1),
      .ac_sense_oscillator_input_fail(osc_fail),
      .below_minimum_hold_current(low_dc),
      .below_minimum_ac_sense_current(4'h0),
      .above_overcurrent_threshold(ovc), .detect_good(4'h0),
      .int_request(int_req), .reg_rdata(reg_rdata), .port_power_on(pwr),
      .detect_enable(unused_a), .classify_enable(unused_b),
      .detect_single(d_single), .classify_single(), .port_clear(unused_c),
      .overcurrent_fault(), .startup_fault(), .disconnect_event(unused_d),
      .device_reset_pulse(dev_rst), .event_clear_all(clr_all),
      .osc_fail_flag_set(osc_set), .alert_response_enable(alert_en),
      .int_out(), .int_oe_n(int_oe_n));
   function automatic logic [31:0] nxt(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : nxt
   task chk(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask : chk
   task wrap_up;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : wrap_up
   task rd(input logic [7:0] a, input logic [7:0] exp);
      q.push_back(exp);
      i_poecfg_host_model.rd(a);
   endtask : rd
   task wt(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : wt
   // read results land at the taken edge and are checked one edge later
   always @(posedge core_clk) begin
      if (rd_pend) begin
         if (q.size() == 0) chk(8'hEE, 8'h00);
         else chk(reg_rdata, q.pop_front());
      end
      rd_pend <= reg_read;
   end
   initial begin
      wt(3);
      reset <= 1'b0;
      wt(12);
      rd(8'h12, 8'hFF);
      rd(8'h13, 8'h0F);
      rd(8'h14, 8'hFF);
      rd(8'h17, 8'hA0);
      for (i = 8'h18; i <= 8'h1A; i++) rd(i[7:0], 8'h00);
      rd(8'h15, 8'h00);
      i_poecfg_host_model.wr(8'h16, 8'hFF);
      rd(8'h16, 8'h3F);
      for (i = 0; i < 4; i++) begin
         i_poecfg_host_model.wr(8'h12, 8'h55 * i[7:0]);
         rd(8'h12, 8'h55 * i[7:0]);
      end
      lfsr = nxt(lfsr);
      i_poecfg_host_model.wr(8'h13, lfsr[15:8]);
      rd(8'h13, lfsr[15:8]);
      i_poecfg_host_model.wr(8'h13, 8'h0F);
      $display("test registers done");
      i_poecfg_host_model.wr(8'h19, 8'h01);
      chk(pwr, 4'h1);
      i_poecfg_host_model.wr(8'h14, 8'hFF);
      i_poecfg_host_model.wr(8'h19, 8'h10);
      chk(pwr, 4'h0);
      rd(8'h14, 8'hEE);
      i_poecfg_host_model.wr(8'h16, 8'h00);
      i_poecfg_host_model.wr(8'h19, 8'h01);
      low_dc <= 4'h1;
      for (i = 0; i < 3000 && pwr[0] !== 1'b0; i++) wt(1);
      if (i == 3000) begin
         n_mismatch++;
         wrap_up;
      end
      chk(pwr, 4'h0);
      low_dc <= 4'h0;
      $display("test power done");
      i_poecfg_host_model.wr(8'h12, 8'hF1);
      i_poecfg_host_model.wr(8'h18, 8'h01);
      chk(d_single, 4'h1);
      i_poecfg_host_model.wr(8'h19, 8'h02);
      chk(pwr, 4'h0);
      ce <= 1'b0;
      i_poecfg_host_model.wr(8'h19, 8'h08);
      ce <= 1'b1;
      wt(1);
      chk(pwr, 4'h0);
      i_poecfg_host_model.wr(8'h14, 8'h00);
      i_poecfg_host_model.wr(8'h18, 8'h44);
      rd(8'h14, 8'h44);
      $display("test manual done");
      i_poecfg_host_model.wr(8'h19, 8'h01);
      wt(20);
      ovc <= 4'h1;
      for (i = 0; i < 3000 && pwr[0] !== 1'b0; i++) wt(1);
      if (i == 3000) begin
         n_mismatch++;
         wrap_up;
      end
      chk(pwr, 4'h0);
      i_poecfg_host_model.wr(8'h19, 8'h01);
      chk(pwr, 4'h0);
      ovc <= 4'h0;
      $display("test fault done");
      osc_fail <= 1'b1;
      int_req <= 1'b1;
      wt(8);
      chk(osc_set, 1'b1);
      chk(int_oe_n, 1'b0);
      i_poecfg_host_model.wr(8'h1A, 8'h40);
      wt(2);
      chk(int_oe_n, 1'b1);
      i_poecfg_host_model.wr(8'h17, 8'h00);
      wt(2);
      chk(osc_set, 1'b0);
      chk(alert_en, 1'b0);
      i_poecfg_host_model.wr(8'h1A, 8'h80);
      chk(clr_all, 1'b1);
      i_poecfg_host_model.wr(8'h1A, 8'h10);
      chk(dev_rst, 1'b1);
      wt(12);
      rd(8'h12, 8'hFF);
      rd(8'h17, 8'hA0);
      wt(3);
      chk(8'(q.size()), 8'h00);
      $display("test interrupt and reset done");
      wrap_up;
   end
endmodule : poecfg_top_tb_top
